// >>> rtl/bdc_core.sv
// Bus datapath core: working registers, operand register, arithmetic unit, result drivers.
// Assumes a synchronous memory with one cycle read latency and AXI4-Lite master on the register bus.
//
// How it works
// - Eighteen-bit datapath; lower bus gathers operands, upper bus spreads results.
// - Lower bus value lands in operand register, held stable during arithmetic.
// - Results go via result drivers to working register, memory or channel.
// - Flags follow each result word: sign, zero and low bit parity.
// - Transmit: register through operand register and arithmetic unit to buffer selector.
// - Receive: buffer selector data enters lower bus, routed to chosen register.
// - Controller selector words move memory to peripheral without touching working registers.
// - Controller selector transfers sequence automatically, address advancing per word.
// - Arithmetic unit takes memory word and operand register at once.
// - Transfer merges up to six sources, writes up to four destinations.
// - Both working registers behave alike; parity network only on second.
// - Seven-bit channel select register names the addressed channel.
// - Channel select register can index memory address formation.
// - Location register holds next access address, keeps last operand address.
// - Decode register captures high seven instruction bits, keeps last opcode.
// - Fourteen-bit instruction counter advances, wrapping freely across banks.
// - Programme-visible fourteen-bit counter serves as elapsed time clock.
// - Eighteen-bit operand register forms and holds intermediate operand.
// - Programme reaches working, channel, instruction and elapsed registers only.
// - Flags update after every instruction, branches included, from result bits.
// - Arithmetic unit adds, ands, ors, xors, shifts, circulates, changes bits, modifies.
//
// The register addresses and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/1ps
module bdc_core #(
  parameter int TICK_CYCLES = bdc_pkg::ETC_TICK_CYC
) (
  // Clock, reset, enable
  input  wire logic                     i_clk,
  input  wire logic                     i_rst_b,
  input  wire logic                     i_ce,
  // AXI4-Lite write
  input  wire logic                     i_awvalid,
  output logic                          o_awready,
  input  wire logic [5:0]               i_awaddr,
  input  wire logic                     i_wvalid,
  output logic                          o_wready,
  input  wire logic [31:0]              i_wdata,
  input  wire logic [3:0]               i_wstrb,
  output logic                          o_bvalid,
  input  wire logic                     i_bready,
  output logic [1:0]                    o_bresp,
  // AXI4-Lite read
  input  wire logic                     i_arvalid,
  output logic                          o_arready,
  input  wire logic [5:0]               i_araddr,
  output logic                          o_rvalid,
  input  wire logic                     i_rready,
  output logic [31:0]                   o_rdata,
  output logic [1:0]                    o_rresp,
  // Memory
  output logic [bdc_pkg::AW-1:0]        o_mem_addr,
  output logic                          o_mem_we,
  output logic [bdc_pkg::DW-1:0]        o_mem_wdata,
  input  wire logic [bdc_pkg::DW-1:0]   i_mem_rdata,
  // Buffer selector
  output logic [bdc_pkg::CW-1:0]        o_chan_sel,
  output logic                          o_tx_valid,
  output bdc_pkg::bdc_tx_t              o_tx,
  input  wire logic [bdc_pkg::DW-1:0]   i_rx_data,
  // Controller selector
  input  wire logic                     i_cs_req,
  input  wire logic                     i_cs_dir,
  input  wire logic [bdc_pkg::DW-1:0]   i_cs_wdata,
  output logic                          o_cs_ack,
  output logic [bdc_pkg::DW-1:0]        o_cs_rdata,
  // Branch flags
  output bdc_pkg::bdc_flags_t           o_flags
);

  localparam int PW = $clog2(TICK_CYCLES + 1);
  localparam logic [PW-1:0] TICK_LAST = PW'(TICK_CYCLES - 1);

  function automatic logic [31:0] merge_strb(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic writable(input logic [5:0] a);
    return a == bdc_pkg::OFF_WR1 || a == bdc_pkg::OFF_WR2 || a == bdc_pkg::OFF_CHAN || a == bdc_pkg::OFF_IAC ||
           a == bdc_pkg::OFF_ETC || a == bdc_pkg::OFF_ADDR || a == bdc_pkg::OFF_CMD || a == bdc_pkg::OFF_CSADDR;
  endfunction

  // Registers
  logic [bdc_pkg::DW-1:0]  wr1_reg, wr2_reg, operand_reg, mem_wdata_reg, cs_rdata_reg;
  logic [bdc_pkg::CW-1:0]  chan_reg;
  logic [bdc_pkg::AW-1:0]  iac_reg, etc_reg, addr_reg, loc_reg, cs_addr_reg;
  logic                    addr_index_reg;
  logic [bdc_pkg::DCW-1:0] decode_reg;
  logic [3:0]              dest_reg;
  logic [PW-1:0]           presc_reg;
  bdc_pkg::bdc_state_t     st_reg;
  bdc_pkg::bdc_flags_t     flags_reg;
  bdc_pkg::bdc_tx_t        tx_reg;
  logic                    tx_valid_reg;
  logic                    aw_full_reg, w_full_reg, bvalid_reg, rvalid_reg;
  logic [5:0]              aw_addr_reg;
  logic [31:0]             w_data_reg, rdata_reg, rd_mux;
  logic [3:0]              w_strb_reg;
  logic [1:0]              bresp_reg, rresp_reg;

  // Combinational datapath
  logic                    wr_fire, wr_ok, cmd_go, exec, tick, dma_ack;
  logic [31:0]             wval, status_word;
  logic [bdc_pkg::DW-1:0]  lower_bus, m_word, alu_z, cmd_word;
  logic [3:0]              op;
  logic [bdc_pkg::AW-1:0]  ea;

  // AXI write channel
  assign o_awready = !aw_full_reg && !bvalid_reg;
  assign o_wready  = !w_full_reg && !bvalid_reg;
  assign o_bvalid  = bvalid_reg;
  assign o_bresp   = bresp_reg;
  assign wr_fire   = i_ce && aw_full_reg && w_full_reg && !bvalid_reg;
  assign wr_ok     = wr_fire && st_reg == bdc_pkg::ST_IDLE && writable(aw_addr_reg);
  assign cmd_go    = wr_ok && aw_addr_reg == bdc_pkg::OFF_CMD;
  assign exec      = i_ce && st_reg == bdc_pkg::ST_EXEC;
  assign wval      = merge_strb(32'h0, w_data_reg, w_strb_reg);

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      aw_full_reg <= 1'b0;
      w_full_reg  <= 1'b0;
      aw_addr_reg <= 6'h00;
      w_data_reg  <= 32'h0;
      w_strb_reg  <= 4'h0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= bdc_pkg::RESP_OKAY;
    end else if (i_ce) begin
      if (i_awvalid && o_awready) begin
        aw_full_reg <= 1'b1;
        aw_addr_reg <= i_awaddr;
      end
      if (i_wvalid && o_wready) begin
        w_full_reg <= 1'b1;
        w_data_reg <= i_wdata;
        w_strb_reg <= i_wstrb;
      end
      if (wr_fire) begin
        aw_full_reg <= 1'b0;
        w_full_reg  <= 1'b0;
        bvalid_reg  <= 1'b1;
        bresp_reg   <= wr_ok ? bdc_pkg::RESP_OKAY : bdc_pkg::RESP_SLVERR;
      end else if (bvalid_reg && i_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // AXI read channel; hidden registers are not mapped
  assign o_arready   = !rvalid_reg;
  assign o_rvalid    = rvalid_reg;
  assign o_rdata     = rdata_reg;
  assign o_rresp     = rresp_reg;
  assign status_word = {28'h0, st_reg != bdc_pkg::ST_IDLE, flags_reg.par, flags_reg.zero, flags_reg.sign};

  always_comb begin
    rd_mux = 32'h0;
    unique case (i_araddr)
      bdc_pkg::OFF_WR1:    rd_mux = {14'h0, wr1_reg};
      bdc_pkg::OFF_WR2:    rd_mux = {14'h0, wr2_reg};
      bdc_pkg::OFF_CHAN:   rd_mux = {25'h0, chan_reg};
      bdc_pkg::OFF_IAC:    rd_mux = {18'h0, iac_reg};
      bdc_pkg::OFF_ETC:    rd_mux = {18'h0, etc_reg};
      bdc_pkg::OFF_ADDR:   rd_mux = {17'h0, addr_index_reg, addr_reg};
      bdc_pkg::OFF_STATUS: rd_mux = status_word;
      bdc_pkg::OFF_CSADDR: rd_mux = {18'h0, cs_addr_reg};
      default:             rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h0;
      rresp_reg  <= bdc_pkg::RESP_OKAY;
    end else if (i_ce) begin
      if (i_arvalid && o_arready) begin
        rvalid_reg <= 1'b1;
        rdata_reg  <= rd_mux;
        rresp_reg  <= (writable(i_araddr) && i_araddr != bdc_pkg::OFF_CMD) || i_araddr == bdc_pkg::OFF_STATUS
                      ? bdc_pkg::RESP_OKAY : bdc_pkg::RESP_SLVERR;
      end else if (rvalid_reg && i_rready) begin
        rvalid_reg <= 1'b0;
      end
    end
  end

  // Lower bus merges the selected sources
  assign cmd_word = wval[bdc_pkg::DW-1:0];
  always_comb begin
    lower_bus = '0;
    if (cmd_word[bdc_pkg::CMD_SRC_LO + bdc_pkg::SRC_WR1])  lower_bus = lower_bus | wr1_reg;
    if (cmd_word[bdc_pkg::CMD_SRC_LO + bdc_pkg::SRC_WR2])  lower_bus = lower_bus | wr2_reg;
    if (cmd_word[bdc_pkg::CMD_SRC_LO + bdc_pkg::SRC_CHAN]) lower_bus = lower_bus | {11'h0, chan_reg};
    if (cmd_word[bdc_pkg::CMD_SRC_LO + bdc_pkg::SRC_IAC])  lower_bus = lower_bus | {4'h0, iac_reg};
    if (cmd_word[bdc_pkg::CMD_SRC_LO + bdc_pkg::SRC_ETC])  lower_bus = lower_bus | {4'h0, etc_reg};
    if (cmd_word[bdc_pkg::CMD_SRC_LO + bdc_pkg::SRC_RX])   lower_bus = lower_bus | i_rx_data;
  end

  // Effective address, optionally indexed by channel select
  assign ea = addr_index_reg ? bdc_pkg::AW'(addr_reg + {7'h0, chan_reg}) : addr_reg;

  // Arithmetic unit on operand register and memory word
  assign op     = decode_reg[6:3];
  assign m_word = decode_reg[bdc_pkg::CMD_MEM - 11] ? i_mem_rdata : '0;
  always_comb begin
    alu_z = operand_reg;
    unique case (op)
      bdc_pkg::OP_ADD:  alu_z = bdc_pkg::DW'(operand_reg + m_word);
      bdc_pkg::OP_AND:  alu_z = operand_reg & m_word;
      bdc_pkg::OP_OR:   alu_z = operand_reg | m_word;
      bdc_pkg::OP_XOR:  alu_z = operand_reg ^ m_word;
      bdc_pkg::OP_SHL:  alu_z = {operand_reg[16:0], 1'b0};
      bdc_pkg::OP_SHR:  alu_z = {1'b0, operand_reg[17:1]};
      bdc_pkg::OP_CIRC: alu_z = {operand_reg[16:0], operand_reg[17]};
      bdc_pkg::OP_BCHG: alu_z = m_word[4:0] < 5'h12 ? operand_reg ^ (18'h00001 << m_word[4:0]) : operand_reg;
      bdc_pkg::OP_AMOD: alu_z = {operand_reg[17:14], bdc_pkg::AW'(operand_reg[13:0] + m_word[13:0])};
      default:          alu_z = operand_reg;
    endcase
  end

  // Sequencer for register transfers and controller selector words
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st_reg      <= bdc_pkg::ST_IDLE;
      operand_reg <= '0;
      loc_reg     <= '0;
      decode_reg  <= '0;
      dest_reg    <= 4'h0;
    end else if (i_ce) begin
      unique case (st_reg)
        bdc_pkg::ST_IDLE: begin
          if (cmd_go) begin
            operand_reg <= lower_bus;
            loc_reg     <= ea;
            decode_reg  <= cmd_word[bdc_pkg::CMD_OP_HI:bdc_pkg::CMD_TX];
            dest_reg    <= cmd_word[bdc_pkg::CMD_DST_HI:bdc_pkg::CMD_DST_LO];
            st_reg      <= bdc_pkg::ST_READ;
          end else if (i_cs_req) begin
            st_reg <= i_cs_dir ? bdc_pkg::ST_DWR : bdc_pkg::ST_DRD;
          end
        end
        bdc_pkg::ST_READ:  st_reg <= bdc_pkg::ST_EXEC;
        bdc_pkg::ST_EXEC:  st_reg <= decode_reg[bdc_pkg::CMD_STORE - 11] ? bdc_pkg::ST_STORE : bdc_pkg::ST_IDLE;
        bdc_pkg::ST_STORE: st_reg <= bdc_pkg::ST_IDLE;
        bdc_pkg::ST_DWR:   st_reg <= bdc_pkg::ST_IDLE;
        bdc_pkg::ST_DRD:   st_reg <= bdc_pkg::ST_DRET;
        bdc_pkg::ST_DRET:  st_reg <= bdc_pkg::ST_DACK;
        bdc_pkg::ST_DACK:  st_reg <= bdc_pkg::ST_IDLE;
        default:           st_reg <= bdc_pkg::ST_IDLE;
      endcase
    end
  end

  // Memory port, shared by operand access and controller selector
  assign dma_ack     = st_reg == bdc_pkg::ST_DWR || st_reg == bdc_pkg::ST_DACK;
  assign o_cs_ack    = dma_ack;
  assign o_cs_rdata  = cs_rdata_reg;
  assign o_mem_we    = st_reg == bdc_pkg::ST_STORE || st_reg == bdc_pkg::ST_DWR;
  assign o_mem_wdata = mem_wdata_reg;
  assign o_mem_addr  = (st_reg == bdc_pkg::ST_DWR || st_reg == bdc_pkg::ST_DRD || st_reg == bdc_pkg::ST_DRET ||
                        st_reg == bdc_pkg::ST_DACK) ? cs_addr_reg : loc_reg;

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      mem_wdata_reg <= '0;
      cs_rdata_reg  <= '0;
    end else if (i_ce) begin
      if (exec) begin
        mem_wdata_reg <= alu_z;
      end else if (st_reg == bdc_pkg::ST_IDLE && !cmd_go && i_cs_req && i_cs_dir) begin
        mem_wdata_reg <= i_cs_wdata;
      end
      if (st_reg == bdc_pkg::ST_DRET) begin
        cs_rdata_reg <= i_mem_rdata;
      end
    end
  end

  // Transmit path to the buffer selector
  assign o_chan_sel = chan_reg;
  assign o_tx_valid = tx_valid_reg;
  assign o_tx       = tx_reg;
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      tx_valid_reg <= 1'b0;
      tx_reg       <= '0;
    end else if (i_ce) begin
      tx_valid_reg <= exec && decode_reg[bdc_pkg::CMD_TX - 11];
      if (exec && decode_reg[bdc_pkg::CMD_TX - 11]) begin
        tx_reg <= '{parity: ^wr2_reg, data: alu_z};
      end
    end
  end

  // Branch flags from the result drivers
  assign o_flags = flags_reg;
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      flags_reg <= '0;
    end else if (exec) begin
      flags_reg <= '{sign: alu_z[17], zero: alu_z == '0, par: alu_z[0]};
    end
  end

  // Working registers and channel select
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wr1_reg  <= '0;
      wr2_reg  <= '0;
      chan_reg <= '0;
    end else if (i_ce) begin
      if (exec) begin
        if (dest_reg[bdc_pkg::DST_WR1])  wr1_reg  <= alu_z;
        if (dest_reg[bdc_pkg::DST_WR2])  wr2_reg  <= alu_z;
        if (dest_reg[bdc_pkg::DST_CHAN]) chan_reg <= alu_z[6:0];
      end else if (wr_ok) begin
        if (aw_addr_reg == bdc_pkg::OFF_WR1)  wr1_reg  <= wval[17:0];
        if (aw_addr_reg == bdc_pkg::OFF_WR2)  wr2_reg  <= wval[17:0];
        if (aw_addr_reg == bdc_pkg::OFF_CHAN) chan_reg <= wval[6:0];
      end
    end
  end

  // Operand address and controller selector address
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      addr_reg       <= '0;
      addr_index_reg <= 1'b0;
      cs_addr_reg    <= '0;
    end else if (i_ce) begin
      if (wr_ok && aw_addr_reg == bdc_pkg::OFF_ADDR) begin
        addr_reg       <= wval[13:0];
        addr_index_reg <= wval[14];
      end
      if (dma_ack) begin
        cs_addr_reg <= cs_addr_reg + 14'h0001;
      end else if (wr_ok && aw_addr_reg == bdc_pkg::OFF_CSADDR) begin
        cs_addr_reg <= wval[13:0];
      end
    end
  end

  // Instruction address counter
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      iac_reg <= '0;
    end else if (i_ce) begin
      if (exec) begin
        iac_reg <= dest_reg[bdc_pkg::DST_IAC] ? alu_z[13:0] : iac_reg + 14'h0001;
      end else if (wr_ok && aw_addr_reg == bdc_pkg::OFF_IAC) begin
        iac_reg <= wval[13:0];
      end
    end
  end

  // Elapsed time counter
  assign tick = i_ce && presc_reg == TICK_LAST;
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      presc_reg <= '0;
      etc_reg   <= '0;
    end else if (i_ce) begin
      presc_reg <= tick ? '0 : presc_reg + PW'(1);
      if (wr_ok && aw_addr_reg == bdc_pkg::OFF_ETC) begin
        etc_reg <= wval[13:0];
      end else if (tick) begin
        etc_reg <= etc_reg + 14'h0001;
      end
    end
  end

  AST_FLAG_SIGN: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    exec |=> o_flags.sign == $past(alu_z[17]))
    else $error("sign flag does not match result bit");

  AST_FLAG_ZERO_PAR: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    exec |=> (o_flags.zero == ($past(alu_z) == '0)) && (o_flags.par == $past(alu_z[0])))
    else $error("zero or parity flag wrong");

  AST_OPERAND_HOLD: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (i_ce && st_reg == bdc_pkg::ST_READ) |=> $stable(operand_reg) ##1 $stable(operand_reg))
    else $error("operand register changed while processing");

  AST_TX_OUT: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (exec && decode_reg[bdc_pkg::CMD_TX - 11]) |=> o_tx_valid && o_tx.data == $past(alu_z))
    else $error("transmit word missing or wrong");

  AST_TX_PARITY: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (exec && decode_reg[bdc_pkg::CMD_TX - 11]) |=> o_tx.parity == ^$past(wr2_reg))
    else $error("transmit parity not from second working register");

  AST_DMA_ADVANCE: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (i_ce && dma_ack) |=> cs_addr_reg == 14'($past(cs_addr_reg) + 14'h0001))
    else $error("controller selector address did not advance");

  AST_DMA_NO_REG: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (i_ce && st_reg == bdc_pkg::ST_DRD) |=> $stable(wr1_reg) && $stable(wr2_reg) ##1 $stable(wr1_reg))
    else $error("working register touched by controller selector transfer");

  AST_IAC_STEP: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (exec && !dest_reg[bdc_pkg::DST_IAC]) |=> iac_reg == 14'($past(iac_reg) + 14'h0001))
    else $error("instruction counter did not advance");

  AST_ETC_TICK: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (tick && !(wr_ok && aw_addr_reg == bdc_pkg::OFF_ETC)) |=> etc_reg == 14'($past(etc_reg) + 14'h0001))
    else $error("elapsed time counter did not tick");

  AST_INDEX_ADDR: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (cmd_go && addr_index_reg) |=> loc_reg == 14'($past(addr_reg) + {7'h0, $past(chan_reg)}))
    else $error("indexed address not formed from channel select");

endmodule // bdc_core

// >>> rtl/bdc_pkg.sv
// Package for the 18-bit bus datapath core: register map, field layout, opcodes, types.
// Assumes a 40 MHz system clock and a 32-bit AXI4-Lite register bus.
package bdc_pkg;

  // Datapath widths
  localparam int DW  = 18;
  localparam int AW  = 14;
  localparam int CW  = 7;
  localparam int DCW = 7;

  // Register byte offsets
  localparam logic [5:0] OFF_WR1    = 6'h00;
  localparam logic [5:0] OFF_WR2    = 6'h04;
  localparam logic [5:0] OFF_CHAN   = 6'h08;
  localparam logic [5:0] OFF_IAC    = 6'h0c;
  localparam logic [5:0] OFF_ETC    = 6'h10;
  localparam logic [5:0] OFF_ADDR   = 6'h14;
  localparam logic [5:0] OFF_CMD    = 6'h18;
  localparam logic [5:0] OFF_STATUS = 6'h1c;
  localparam logic [5:0] OFF_CSADDR = 6'h20;

  // Command word fields
  localparam int CMD_OP_HI  = 17;
  localparam int CMD_OP_LO  = 14;
  localparam int CMD_MEM    = 13;
  localparam int CMD_STORE  = 12;
  localparam int CMD_TX     = 11;
  localparam int CMD_SRC_HI = 10;
  localparam int CMD_SRC_LO = 5;
  localparam int CMD_DST_HI = 4;
  localparam int CMD_DST_LO = 1;
  localparam int CMD_INDEX  = 0;

  // Source select bits
  localparam int SRC_WR1  = 0;
  localparam int SRC_WR2  = 1;
  localparam int SRC_CHAN = 2;
  localparam int SRC_IAC  = 3;
  localparam int SRC_ETC  = 4;
  localparam int SRC_RX   = 5;

  // Destination select bits
  localparam int DST_WR1  = 0;
  localparam int DST_WR2  = 1;
  localparam int DST_CHAN = 2;
  localparam int DST_IAC  = 3;

  // Status fields
  localparam int ST_SIGN = 0;
  localparam int ST_ZERO = 1;
  localparam int ST_PAR  = 2;
  localparam int ST_BUSY = 3;

  // Arithmetic unit opcodes
  localparam logic [3:0] OP_PASS = 4'h0;
  localparam logic [3:0] OP_ADD  = 4'h1;
  localparam logic [3:0] OP_AND  = 4'h2;
  localparam logic [3:0] OP_OR   = 4'h3;
  localparam logic [3:0] OP_XOR  = 4'h4;
  localparam logic [3:0] OP_SHL  = 4'h5;
  localparam logic [3:0] OP_SHR  = 4'h6;
  localparam logic [3:0] OP_CIRC = 4'h7;
  localparam logic [3:0] OP_BCHG = 4'h8;
  localparam logic [3:0] OP_AMOD = 4'h9;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Elapsed time tick
  localparam int CLK_MHZ      = 40;
  localparam int ETC_TICK_US  = 1000;
  localparam int ETC_TICK_CYC = ETC_TICK_US * CLK_MHZ;

  typedef enum logic [2:0] {ST_IDLE, ST_READ, ST_EXEC, ST_STORE, ST_DWR, ST_DRD, ST_DRET, ST_DACK} bdc_state_t;

  typedef struct packed {
    logic          parity;
    logic [DW-1:0] data;
  } bdc_tx_t;

  typedef struct packed {
    logic sign;
    logic zero;
    logic par;
  } bdc_flags_t;

endpackage

// >>> verif/bdc_core_bench.sv
// Self-checking bench: AXI4-Lite register tasks, controller selector word task.
// Assumes bdc_core, bdc_pkg and the bdc_partner model.
`timescale 1ns/1ps
module bdc_core_bench;
  logic i_clk = 0, i_rst_b = 0, awv = 0, wv = 0, bready = 0, arv = 0, rready = 0, cs_req = 0, cs_dir = 0;
  logic awready, wready, bvalid, arready, rvalid, mem_we, tx_valid, cs_ack;
  logic [5:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, got, g1;
  logic ce = 1;
  logic [1:0] bresp, rresp, r;
  logic [17:0] mem_rdata, rx_data, mem_wdata, cs_wdata = 0, cs_rdata;
  logic [13:0] mem_addr;
  logic [6:0] chan_sel;
  bdc_pkg::bdc_tx_t tx, tx_seen = '0;
  bdc_pkg::bdc_flags_t flags;
  int mismatches = 0, n_tests = 0;
  always #12.5 i_clk = ~i_clk;
  always @(posedge i_clk) if (tx_valid) tx_seen <= tx;
  bdc_core #(.TICK_CYCLES(4)) bdc_core_inst (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_ce(ce),
    .i_awvalid(awv), .o_awready(awready), .i_awaddr(awaddr), .i_wvalid(wv), .o_wready(wready),
    .i_wdata(wdata), .i_wstrb(4'hf), .o_bvalid(bvalid), .i_bready(bready), .o_bresp(bresp),
    .i_arvalid(arv), .o_arready(arready), .i_araddr(araddr), .o_rvalid(rvalid), .i_rready(rready),
    .o_rdata(rdata), .o_rresp(rresp), .o_mem_addr(mem_addr), .o_mem_we(mem_we), .o_mem_wdata(mem_wdata),
    .i_mem_rdata(mem_rdata), .o_chan_sel(chan_sel), .o_tx_valid(tx_valid), .o_tx(tx), .i_rx_data(rx_data),
    .i_cs_req(cs_req), .i_cs_dir(cs_dir), .i_cs_wdata(cs_wdata), .o_cs_ack(cs_ack),
    .o_cs_rdata(cs_rdata), .o_flags(flags));
  bdc_partner bdc_partner_inst (.i_clk(i_clk), .i_mem_addr(mem_addr), .i_mem_we(mem_we),
    .i_mem_wdata(mem_wdata), .o_mem_rdata(mem_rdata), .o_rx_data(rx_data));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic done = 0;
    @(posedge i_clk); awv <= 1; wv <= 1; awaddr <= a; wdata <= d; bready <= 1;
    while (!done) begin
      @(posedge i_clk);
      if (awv && awready) awv <= 0;
      if (wv && wready) wv <= 0;
      if (bvalid) begin r = bresp; bready <= 0; done = 1; end
    end
  endtask
  task automatic rd(input logic [5:0] a);
    logic done = 0;
    @(posedge i_clk); arv <= 1; araddr <= a; rready <= 1;
    while (!done) begin
      @(posedge i_clk);
      if (arv && arready) arv <= 0;
      if (rvalid) begin got = rdata; r = rresp; rready <= 0; done = 1; end
    end
  endtask
  task automatic run(input logic [31:0] c);
    wr(bdc_pkg::OFF_CMD, c);
    do rd(bdc_pkg::OFF_STATUS); while (got[3] !== 1'b0);
  endtask
  task automatic cs(input logic d, input logic [17:0] x);
    logic done = 0;
    @(posedge i_clk); cs_req <= 1; cs_dir <= d; cs_wdata <= x;
    while (!done) begin
      @(posedge i_clk);
      if (cs_ack) begin cs_req <= 0; done = 1; end
    end
  endtask
  task automatic finish_test;
    if (mismatches == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge i_clk);
    i_rst_b <= 1;
    rd(bdc_pkg::OFF_WR1); chk("wr1_reset", 32'h0, got);
    wr(bdc_pkg::OFF_CHAN, 32'h7f); chk("chan_sel", 32'h7f, {25'h0, chan_sel});
    chk("bresp_ok", 32'h0, {30'h0, r});
    wr(bdc_pkg::OFF_WR1, 32'h5); run(32'h24); rd(bdc_pkg::OFF_WR2); chk("wr2", 32'h5, got);
    chk("flags_odd", 32'h1, {29'h0, flags});
    run(32'h0); chk("flags_zero", 32'h2, {29'h0, flags});
    wr(bdc_pkg::OFF_CSADDR, 32'h3); cs(1'b1, 18'h3fffb);
    wr(bdc_pkg::OFF_ADDR, 32'h3); run(32'h6022); rd(bdc_pkg::OFF_WR1); chk("add_mem", 32'h0, got);
    chk("flags_add", 32'h2, {29'h0, flags});
    wr(bdc_pkg::OFF_CSADDR, 32'h3); cs(1'b0, 18'h0); chk("cs_rdata", 32'h3fffb, {14'h0, cs_rdata});
    rd(bdc_pkg::OFF_CSADDR); chk("cs_addr", 32'h4, got);
    wr(bdc_pkg::OFF_WR2, 32'h7); run(32'hc02); rd(bdc_pkg::OFF_WR1); chk("rx_wr1", 32'h20001, got);
    chk("flags_neg", 32'h5, {29'h0, flags});
    chk("tx_word", 32'h60001, {13'h0, tx_seen});
    wr(bdc_pkg::OFF_ADDR, 32'h4001); run(32'h1020);
    wr(bdc_pkg::OFF_CSADDR, 32'h80); cs(1'b0, 18'h0); chk("store_idx", 32'h20001, {14'h0, cs_rdata});
    rd(bdc_pkg::OFF_IAC); chk("iac_count", 32'h5, got);
    wr(bdc_pkg::OFF_ETC, 32'h0); repeat (40) @(posedge i_clk);
    rd(bdc_pkg::OFF_ETC); chk("etc_count", 32'h1, {31'h0, got >= 10 && got <= 11});
    g1 = got; @(posedge i_clk); ce <= 1'b0; repeat (40) @(posedge i_clk); ce <= 1'b1;
    rd(bdc_pkg::OFF_ETC); chk("etc_frozen", 32'h1, {31'h0, (got - g1) < 3});
    wr(bdc_pkg::OFF_STATUS, 32'h0); chk("status_wr", 32'h2, {30'h0, r});
    rd(6'h24); chk("unmapped", 32'h2, {30'h0, r});
    rd(bdc_pkg::OFF_CMD); chk("cmd_read", 32'h2, {30'h0, r});
    finish_test;
  end
  initial begin
    repeat (5000) @(posedge i_clk);
    mismatches++;
    finish_test;
  end
endmodule // bdc_core_bench

// >>> verif/bdc_partner.sv
// Far-side model: synchronous memory and buffer selector receive lines.
// Assumes one clock and a memory read latency of one cycle.
`timescale 1ns/1ps
module bdc_partner (
  // Memory
  input  wire logic        i_clk,
  input  wire logic [13:0] i_mem_addr,
  input  wire logic        i_mem_we,
  input  wire logic [17:0] i_mem_wdata,
  output logic      [17:0] o_mem_rdata,
  // Receive lines
  output logic      [17:0] o_rx_data
);
  logic [17:0] mem_reg [16];
  assign o_rx_data = 18'h20001;
  always_ff @(posedge i_clk) begin
    if (i_mem_we) mem_reg[i_mem_addr[3:0]] <= i_mem_wdata;
    o_mem_rdata <= mem_reg[i_mem_addr[3:0]];
  end
endmodule // bdc_partner
